// ==== include/vsd_pkg.sv ====
/*
  Constants for the bus slave address decoder: address modifier codes,
  base address layout, reset values.
  Assumes a bus front end that presents address, modifier and strobe levels.
*/
package vsd_pkg;
  // Address modifier codes, 24-bit space
  localparam logic [5:0] AM_A24_SUP_BLT = 6'h3F;
  localparam logic [5:0] AM_A24_SUP_DATA = 6'h3D;
  localparam logic [5:0] AM_A24_SUP_MBLT = 6'h3C;
  localparam logic [5:0] AM_A24_USR_BLT = 6'h3B;
  localparam logic [5:0] AM_A24_USR_DATA = 6'h39;
  localparam logic [5:0] AM_A24_USR_MBLT = 6'h38;
  // Configuration space
  localparam logic [5:0] AM_CR_CSR = 6'h2F;
  // Address modifier codes, 32-bit space
  localparam logic [5:0] AM_A32_SUP_BLT = 6'h0F;
  localparam logic [5:0] AM_A32_SUP_DATA = 6'h0D;
  localparam logic [5:0] AM_A32_SUP_MBLT = 6'h0C;
  localparam logic [5:0] AM_A32_USR_BLT = 6'h0B;
  localparam logic [5:0] AM_A32_USR_DATA = 6'h09;
  localparam logic [5:0] AM_A32_USR_MBLT = 6'h08;
  // Reset values; multicast middle byte compare value
  localparam logic [7:0] MCST_BYTE_RESET = 8'hAA;
  localparam logic [7:0] BASE_HIGH_RESET = 8'h00;
  localparam logic [7:0] BASE_LOW_RESET = 8'h00;
  localparam logic ADDR_SRC_RESET = 1'b0;
  localparam logic [7:0] MCST_MID_BYTE = 8'h00;
  // Input synchroniser depth
  localparam int SYNC_STAGES = 3;
  // Decoded cycle kind
  typedef enum logic [2:0] {
    VSD_KIND_NONE, VSD_KIND_SINGLE, VSD_KIND_BLT, VSD_KIND_MBLT, VSD_KIND_CSR
  } vsd_kind_t;
  // Address space
  typedef enum logic [1:0] {VSD_SP_NONE, VSD_SP_A24, VSD_SP_A32, VSD_SP_CSR} vsd_space_t;
endpackage

// ==== include/vsd_sync_if.sv ====
/*
  Carrier between the decoder and its pin synchroniser.
  Assumes one clock domain; raw pins in, clean levels out.
*/
`timescale 1ns/1ns
interface vsd_sync_if;
  logic as_raw_n;
  logic [5:0] am_raw;
  logic [31:1] addr_raw;
  logic as_n;
  logic as_valid;
  logic [5:0] am;
  logic [31:1] addr;
  modport filt(input as_raw_n, input am_raw, input addr_raw, output as_n, output as_valid, output am,
    output addr);
  modport user(output as_raw_n, output am_raw, output addr_raw, input as_n, input as_valid, input am,
    input addr);
endinterface

// ==== core/vsd_sync.sv ====
/*
  Three-stage synchroniser for the address strobe, modifier and address.
  Assumes address and modifier are stable while the strobe is asserted.
*/
`timescale 1ns/1ns
module vsd_sync (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Pins in, clean levels out
  vsd_sync_if.filt sif
);
  logic [37:0] s1, s2, s3;
  logic [37:0] next_s1, next_s2, next_s3;
  logic as_n, next_as_n;

  // Shift chain; strobe level only moves when stages two and three agree
  always_comb begin
    next_s1 = {sif.as_raw_n, sif.am_raw, sif.addr_raw};
    next_s2 = s1;
    next_s3 = s2;
    next_as_n = (s2[37] == s3[37]) ? s3[37] : as_n;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s1 <= {1'b1, 37'h0};
      s2 <= {1'b1, 37'h0};
      s3 <= {1'b1, 37'h0};
      as_n <= 1'b1;
    end else begin
      s1 <= next_s1;
      s2 <= next_s2;
      s3 <= next_s3;
      as_n <= next_as_n;
    end
  end

  // Address taken from the last stage, a cycle ahead of the strobe settling
  assign sif.as_n = as_n;
  assign sif.as_valid = !as_n && !s3[37];
  assign sif.am = s3[36:31];
  assign sif.addr = s3[30:0];
endmodule

// ==== core/vsd_decode.sv ====
/*
  Bus slave address decoder: classifies each cycle by address modifier and
  compares upper address bits with the selected base or the multicast byte.
  Assumes a front end that drives the acknowledge from the select output and
  programs base, source and multicast byte through plain inputs.
*/
// Function
// - Take 24-bit single cycles on modifier 3D or 39.
// - Take 24-bit block transfers on modifier 3F or 3B.
// - Take 24-bit 64-bit block transfers on modifier 3C or 38.
// - Answer configuration ROM and control space cycles on modifier 2F.
// - Take 32-bit single cycles on modifier 0D or 09.
// - Take 32-bit block transfers on modifier 0F or 0B.
// - Take 32-bit 64-bit block transfers on modifier 0C or 08.
// - Base address set in 64 KiB steps in both address spaces.
// - Source bit clear, the reset default, selects rotary switch base.
// - Source bit set selects the two programmable base bytes.
// - High byte gives address 31..24, low byte address 23..16.
// - Register accesses use 16-bit or 32-bit data only.
// - Readout by single, block and 64-bit block cycles.
// - Interrupter on seven levels, released by a register access.
// - Selection by 24-bit, 32-bit, geographical or multicast addressing.
// - Multicast matches shared byte on 31..24, zero on 23..16.
`timescale 1ns/1ns
module vsd_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Bus address phase pins
  input wire logic as_pin_n,
  input wire logic [5:0] am_pin,
  input wire logic [31:1] addr_pin,
  input wire logic lword_n,
  input wire logic ds0_n,
  input wire logic ds1_n,
  // Base address sources
  input wire logic [7:0] rotary_high,
  input wire logic [7:0] rotary_low,
  input wire logic base_src_wr,
  input wire logic base_src_in,
  input wire logic base_wr,
  input wire logic [7:0] base_high_in,
  input wire logic [7:0] base_low_in,
  input wire logic mcst_wr,
  input wire logic [7:0] mcst_byte_in,
  input wire logic [4:0] geo_addr,
  // Interrupter
  input wire logic irq_event,
  input wire logic [2:0] irq_level,
  // Decode results
  output logic select,
  output logic mcst_select,
  output logic csr_select,
  output vsd_pkg::vsd_kind_t cycle_kind,
  output logic is_a32,
  output logic [15:0] offset,
  output logic reg_width_ok,
  output logic readout_ok,
  output logic [6:0] irq_n,
  output logic base_src,
  output logic [7:0] base_high,
  output logic [7:0] base_low,
  output logic [7:0] mcst_byte
);
  vsd_sync_if sif();

  logic select_d, mcst_d, csr_d, a32_d, width_d, readout_d, src_d;
  logic [15:0] offset_d;
  logic [6:0] irq_n_d;
  logic [7:0] high_d, low_d, mcst_byte_d;
  vsd_pkg::vsd_kind_t kind_d;
  logic next_select, next_mcst, next_csr, next_a32, next_width, next_readout, next_src;
  logic [15:0] next_offset;
  logic [6:0] next_irq_n;
  logic [7:0] next_high, next_low, next_mcst_byte;
  vsd_pkg::vsd_kind_t next_kind;
  vsd_pkg::vsd_space_t sp;
  vsd_pkg::vsd_kind_t kd;
  logic [7:0] sel_high, sel_low;
  logic [1:0] ds_s1, ds_s2, ds_s3;
  logic [1:0] next_ds_s1, next_ds_s2, next_ds_s3;

  assign sif.as_raw_n = as_pin_n;
  assign sif.am_raw = am_pin;
  assign sif.addr_raw = addr_pin;

  vsd_sync u_sync (
    .clk(clk),
    .reset_n(reset_n),
    .sif(sif)
  );

  // Data strobe pins through three stages, like the address path
  always_comb begin
    next_ds_s1 = {ds1_n, ds0_n};
    next_ds_s2 = ds_s1;
    next_ds_s3 = ds_s2;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      ds_s1 <= 2'h3;
      ds_s2 <= 2'h3;
      ds_s3 <= 2'h3;
    end else begin
      ds_s1 <= next_ds_s1;
      ds_s2 <= next_ds_s2;
      ds_s3 <= next_ds_s3;
    end
  end

  // Modifier to space
  function automatic vsd_pkg::vsd_space_t am_space(input logic [5:0] am);
    case (am)
      vsd_pkg::AM_A24_SUP_DATA, vsd_pkg::AM_A24_USR_DATA,
      vsd_pkg::AM_A24_SUP_BLT, vsd_pkg::AM_A24_USR_BLT,
      vsd_pkg::AM_A24_SUP_MBLT, vsd_pkg::AM_A24_USR_MBLT: am_space = vsd_pkg::VSD_SP_A24;
      vsd_pkg::AM_A32_SUP_DATA, vsd_pkg::AM_A32_USR_DATA,
      vsd_pkg::AM_A32_SUP_BLT, vsd_pkg::AM_A32_USR_BLT,
      vsd_pkg::AM_A32_SUP_MBLT, vsd_pkg::AM_A32_USR_MBLT: am_space = vsd_pkg::VSD_SP_A32;
      vsd_pkg::AM_CR_CSR: am_space = vsd_pkg::VSD_SP_CSR;
      default: am_space = vsd_pkg::VSD_SP_NONE;
    endcase
  endfunction

  // Modifier to transfer kind
  function automatic vsd_pkg::vsd_kind_t am_kind(input logic [5:0] am);
    case (am)
      vsd_pkg::AM_A24_SUP_DATA, vsd_pkg::AM_A24_USR_DATA,
      vsd_pkg::AM_A32_SUP_DATA, vsd_pkg::AM_A32_USR_DATA: am_kind = vsd_pkg::VSD_KIND_SINGLE;
      vsd_pkg::AM_A24_SUP_BLT, vsd_pkg::AM_A24_USR_BLT,
      vsd_pkg::AM_A32_SUP_BLT, vsd_pkg::AM_A32_USR_BLT: am_kind = vsd_pkg::VSD_KIND_BLT;
      vsd_pkg::AM_A24_SUP_MBLT, vsd_pkg::AM_A24_USR_MBLT,
      vsd_pkg::AM_A32_SUP_MBLT, vsd_pkg::AM_A32_USR_MBLT: am_kind = vsd_pkg::VSD_KIND_MBLT;
      vsd_pkg::AM_CR_CSR: am_kind = vsd_pkg::VSD_KIND_CSR;
      default: am_kind = vsd_pkg::VSD_KIND_NONE;
    endcase
  endfunction

  // Programmable state: source bit, base bytes, multicast byte
  always_comb begin
    next_src = src_d;
    next_high = high_d;
    next_low = low_d;
    next_mcst_byte = mcst_byte_d;
    if (base_src_wr) begin
      next_src = base_src_in;
    end
    if (base_wr) begin
      next_high = base_high_in;
      next_low = base_low_in;
    end
    if (mcst_wr) begin
      next_mcst_byte = mcst_byte_in;
    end
  end

  // Base selection; switches by default, registers when source bit is set
  always_comb begin
    sel_high = rotary_high;
    sel_low = rotary_low;
    if (src_d) begin
      sel_high = high_d;
      sel_low = low_d;
    end
  end

  // Address decode, evaluated every cycle the strobe is low
  always_comb begin
    sp = am_space(sif.am);
    kd = am_kind(sif.am);
    next_select = 1'b0;
    next_mcst = 1'b0;
    next_csr = 1'b0;
    next_a32 = (sp == vsd_pkg::VSD_SP_A32);
    next_kind = vsd_pkg::VSD_KIND_NONE;
    next_offset = {sif.addr[15:1], 1'b0};
    // width check
    // Width only moves once stages two and three agree
    next_width = (ds_s2 == ds_s3) ? (ds_s3 == 2'h0) : width_d;
    next_readout = (kd != vsd_pkg::VSD_KIND_NONE) && (kd != vsd_pkg::VSD_KIND_CSR);
    if (sif.as_valid) begin
      case (sp)
        vsd_pkg::VSD_SP_A24: next_select = (sif.addr[23:16] == sel_low);
        vsd_pkg::VSD_SP_A32: begin
          next_select = ({sif.addr[31:24], sif.addr[23:16]} == {sel_high, sel_low});
          next_mcst = (sif.addr[31:24] == mcst_byte_d) && (sif.addr[23:16] == vsd_pkg::MCST_MID_BYTE)
            && (kd != vsd_pkg::VSD_KIND_MBLT);
        end
        vsd_pkg::VSD_SP_CSR: next_csr = (sif.addr[23:19] == geo_addr);
        default: next_select = 1'b0;
      endcase
      if (next_select || next_mcst || next_csr) begin
        next_kind = kd;
      end
    end
  end

  // Interrupter: request on chosen level, released on a single-cycle base address access
  always_comb begin
    next_irq_n = irq_n_d;
    if (select_d && cycle_kind == vsd_pkg::VSD_KIND_SINGLE) begin
      next_irq_n = 7'h7F;
    end
    // New request wins in the release cycle, but a standing access releases it again at the next edge
    if (irq_event && irq_level != 3'h0) begin
      next_irq_n = 7'h7F & ~(7'h01 << (irq_level - 3'h1));
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      src_d <= vsd_pkg::ADDR_SRC_RESET;
      high_d <= vsd_pkg::BASE_HIGH_RESET;
      low_d <= vsd_pkg::BASE_LOW_RESET;
      mcst_byte_d <= vsd_pkg::MCST_BYTE_RESET;
      select_d <= 1'b0;
      mcst_d <= 1'b0;
      csr_d <= 1'b0;
      a32_d <= 1'b0;
      kind_d <= vsd_pkg::VSD_KIND_NONE;
      offset_d <= 16'h0000;
      width_d <= 1'b0;
      readout_d <= 1'b0;
      irq_n_d <= 7'h7F;
    end else begin
      src_d <= next_src;
      high_d <= next_high;
      low_d <= next_low;
      mcst_byte_d <= next_mcst_byte;
      select_d <= next_select;
      mcst_d <= next_mcst;
      csr_d <= next_csr;
      a32_d <= next_a32;
      kind_d <= next_kind;
      offset_d <= next_offset;
      width_d <= next_width;
      readout_d <= next_readout;
      irq_n_d <= next_irq_n;
    end
  end

  assign select = select_d;
  assign mcst_select = mcst_d;
  assign csr_select = csr_d;
  assign cycle_kind = kind_d;
  assign is_a32 = a32_d;
  assign offset = offset_d;
  assign reg_width_ok = width_d;
  assign readout_ok = readout_d;
  assign irq_n = irq_n_d;
  assign base_src = src_d;
  assign base_high = high_d;
  assign base_low = low_d;
  assign mcst_byte = mcst_byte_d;
endmodule

// ==== tb/vsd_chk.sv ====
/* Checker for the address decoder outputs.
   Assumes pins held steady while the strobe is low. */
`timescale 1ns/1ns
module vsd_chk (
  // Clock, reset, pins
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] am_pin,
  input wire logic [31:1] addr_pin,
  // Base sources
  input wire logic [7:0] rotary_high,
  input wire logic [7:0] rotary_low,
  input wire logic [4:0] geo_addr,
  input wire logic irq_event,
  input wire logic [2:0] irq_level,
  // Results
  input wire logic select,
  input wire logic mcst_select,
  input wire logic csr_select,
  input wire vsd_pkg::vsd_kind_t cycle_kind,
  input wire logic is_a32,
  input wire logic [15:0] offset,
  input wire logic [6:0] irq_n,
  input wire logic base_src,
  input wire logic [7:0] base_high,
  input wire logic [7:0] base_low,
  input wire logic [7:0] mcst_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Answers trail the pins by five edges
  property p_sgl;
    cycle_kind == vsd_pkg::VSD_KIND_SINGLE |-> $past(am_pin, 5) inside {6'h3D, 6'h39, 6'h0D, 6'h09};
  endproperty
  a_sgl: assert property (p_sgl) else $error("single kind on wrong modifier");
  property p_mblt;
    cycle_kind == vsd_pkg::VSD_KIND_MBLT |-> $past(am_pin, 5) inside {6'h3C, 6'h38, 6'h0C, 6'h08};
  endproperty
  a_mblt: assert property (p_mblt) else $error("wide block kind on wrong modifier");
  property p_a24;
    select && !is_a32 |-> $past(addr_pin[23:16], 5) == (base_src ? base_low : rotary_low);
  endproperty
  a_a24: assert property (p_a24) else $error("short space select without base match");
  property p_a32;
    select && is_a32 |-> $past(addr_pin[31:16], 5) == (base_src ? {base_high, base_low} : {rotary_high, rotary_low});
  endproperty
  a_a32: assert property (p_a32) else $error("long space select without base match");
  property p_off;
    select |-> offset == {$past(addr_pin[15:1], 5), 1'b0};
  endproperty
  a_off: assert property (p_off) else $error("offset not the low address bits");
  property p_mcst;
    mcst_select |-> $past(addr_pin[31:16], 5) == {mcst_byte, 8'h00}
      && $past(am_pin, 5) inside {6'h0F, 6'h0D, 6'h0B, 6'h09};
  endproperty
  a_mcst: assert property (p_mcst) else $error("multicast select without match");
  property p_csr;
    csr_select |-> $past(am_pin, 5) == 6'h2F && $past(addr_pin[23:19], 5) == geo_addr;
  endproperty
  a_csr: assert property (p_csr) else $error("config space select without slot match");
  property p_none;
    cycle_kind != vsd_pkg::VSD_KIND_NONE |-> select || mcst_select || csr_select;
  endproperty
  a_none: assert property (p_none) else $error("cycle kind shown without select");
  property p_irq;
    irq_event && irq_level != 3'h0 |=> !irq_n[$past(irq_level) - 1];
  endproperty
  a_irq: assert property (p_irq) else $error("request line not raised");
  property p_rel;
    select && cycle_kind == vsd_pkg::VSD_KIND_SINGLE && !(irq_event && irq_level != 3'h0) |=> irq_n == 7'h7F;
  endproperty
  a_rel: assert property (p_rel) else $error("request not released on access");
  // Main scenarios reached
  c_mcst: cover property (mcst_select);
  c_csr: cover property (csr_select);
  c_mblt: cover property (cycle_kind == vsd_pkg::VSD_KIND_MBLT);
endmodule
bind vsd_decode vsd_chk chk_u (
  .clk(clk), .reset_n(reset_n), .am_pin(am_pin), .addr_pin(addr_pin),
  .rotary_high(rotary_high), .rotary_low(rotary_low), .geo_addr(geo_addr),
  .irq_event(irq_event), .irq_level(irq_level),
  .select(select), .mcst_select(mcst_select), .csr_select(csr_select), .cycle_kind(cycle_kind),
  .is_a32(is_a32), .offset(offset), .irq_n(irq_n), .base_src(base_src),
  .base_high(base_high), .base_low(base_low), .mcst_byte(mcst_byte)
);

// ==== tb/vsd_master.sv ====
/* Bus master model: drives one address phase at a time.
   Assumes start and stop are called just after a clock edge. */
`timescale 1ns/1ns
module vsd_master (
  // Address phase pins
  output logic as_pin_n,
  output logic [5:0] am_pin,
  output logic [31:1] addr_pin,
  output logic ds0_n,
  output logic ds1_n,
  output logic lword_n
);
  // Idle bus at time zero
  initial begin
    {as_pin_n, am_pin, addr_pin, ds0_n, ds1_n, lword_n} = '1;
  end
  // strobe pair for 16 or 32 bits, or ds0 alone when odd_ds is set
  task start(input logic [5:0] am, input logic [31:1] a, input logic odd_ds);
    am_pin = am;
    addr_pin = a;
    lword_n = 1'b0;
    ds0_n = 1'b0;
    ds1_n = odd_ds;
    as_pin_n = 1'b0;
  endtask
  // Released lines show the inverse, never a stale copy
  task stop;
    as_pin_n = 1'b1;
    {ds0_n, ds1_n} = 2'h3;
    am_pin = ~am_pin;
    addr_pin = ~addr_pin;
  endtask
endmodule

// ==== tb/tb.sv ====
/* Self-checking bench for the address decoder.
   Assumes the master model drives the pins and the checker is bound. */
`timescale 1ns/1ns
module tb;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic as_pin_n, lword_n, ds0_n, ds1_n, select, mcst_select, csr_select, is_a32, reg_width_ok, readout_ok, base_src;
  logic base_src_wr = 1'b0, base_src_in = 1'b0, base_wr = 1'b0, mcst_wr = 1'b0, irq_event = 1'b0;
  logic [5:0] am_pin;
  logic [31:1] addr_pin;
  logic [7:0] rotary_high = 8'h00, rotary_low = 8'h00, base_high_in = 8'h00, base_low_in = 8'h00;
  logic [7:0] mcst_byte_in = 8'h00, base_high, base_low, mcst_byte;
  logic [4:0] geo_addr = 5'h0B;
  logic [2:0] irq_level = 3'h0;
  logic [15:0] offset;
  logic [6:0] irq_n;
  logic [5:0] ams [13] = '{6'h3F, 6'h3D, 6'h3C, 6'h3B, 6'h39, 6'h38, 6'h2F, 6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08};
  vsd_pkg::vsd_kind_t cycle_kind;
  int errors = 0, compares = 0, seed = 32'hD91418C2;
  vsd_decode dut_u (
    .clk(clk), .reset_n(reset_n),
    .as_pin_n(as_pin_n), .am_pin(am_pin), .addr_pin(addr_pin),
    .lword_n(lword_n), .ds0_n(ds0_n), .ds1_n(ds1_n),
    .rotary_high(rotary_high), .rotary_low(rotary_low),
    .base_src_wr(base_src_wr), .base_src_in(base_src_in),
    .base_wr(base_wr), .base_high_in(base_high_in), .base_low_in(base_low_in),
    .mcst_wr(mcst_wr), .mcst_byte_in(mcst_byte_in), .geo_addr(geo_addr),
    .irq_event(irq_event), .irq_level(irq_level),
    .select(select), .mcst_select(mcst_select), .csr_select(csr_select),
    .cycle_kind(cycle_kind), .is_a32(is_a32), .offset(offset),
    .reg_width_ok(reg_width_ok), .readout_ok(readout_ok), .irq_n(irq_n),
    .base_src(base_src), .base_high(base_high), .base_low(base_low), .mcst_byte(mcst_byte)
  );
  vsd_master m_u (
    .as_pin_n(as_pin_n), .am_pin(am_pin), .addr_pin(addr_pin),
    .ds0_n(ds0_n), .ds1_n(ds1_n), .lword_n(lword_n)
  );
  always #5 clk = ~clk;
  // One comparison, four-state exact
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic vsd_pkg::vsd_kind_t ek(input logic [5:0] am);
    case (am)
      6'h3D, 6'h39, 6'h0D, 6'h09: return vsd_pkg::VSD_KIND_SINGLE;
      6'h3F, 6'h3B, 6'h0F, 6'h0B: return vsd_pkg::VSD_KIND_BLT;
      6'h3C, 6'h38, 6'h0C, 6'h08: return vsd_pkg::VSD_KIND_MBLT;
      6'h2F: return vsd_pkg::VSD_KIND_CSR;
      default: return vsd_pkg::VSD_KIND_NONE;
    endcase
  endfunction
  // Pins held over six edges, then sampled once settled
  task automatic acc(input logic [5:0] am, input logic [31:1] a, input logic odd_ds);
    m_u.start(am, a, odd_ds);
    repeat (6) @(posedge clk);
    #1;
  endtask
  // Strobe back high, outputs let drop
  task automatic fin;
    m_u.stop();
    repeat (8) @(posedge clk);
    #1;
  endtask
  // Cycle against base b; a miss flips slot or bit 16
  task automatic try(input logic [5:0] am, input logic [15:0] b, input logic hit);
    vsd_pkg::vsd_kind_t k;
    logic [15:0] off;
    logic [31:1] a;
    off = 16'($random(seed));
    k = hit ? ek(am) : vsd_pkg::VSD_KIND_NONE;
    a = {b ^ (hit ? 16'h0000 : 16'h0001), off[15:1]};
    if (am == 6'h2F) a = {8'h00, geo_addr ^ (hit ? 5'h00 : 5'h01), 3'h0, off[15:1]};
    acc(am, a, 1'b0);
    chk(cycle_kind, k);
    chk(csr_select, k == vsd_pkg::VSD_KIND_CSR);
    chk(select, k inside {vsd_pkg::VSD_KIND_SINGLE, vsd_pkg::VSD_KIND_BLT, vsd_pkg::VSD_KIND_MBLT});
    chk(readout_ok, ek(am) inside {vsd_pkg::VSD_KIND_SINGLE, vsd_pkg::VSD_KIND_BLT, vsd_pkg::VSD_KIND_MBLT});
    chk(is_a32, am inside {6'h0F, 6'h0D, 6'h0C, 6'h0B, 6'h09, 6'h08});
    if (k inside {vsd_pkg::VSD_KIND_SINGLE, vsd_pkg::VSD_KIND_BLT, vsd_pkg::VSD_KIND_MBLT}) begin
      chk(offset, {off[15:1], 1'b0});
      chk(reg_width_ok, 1'b1);
    end
    fin;
  endtask
  initial begin
    rotary_high = 8'($random(seed));
    rotary_low = 8'($random(seed));
    repeat (16) @(posedge clk);
    #1 reset_n = 1'b1;
    chk(base_src, 1'b0);
    chk(mcst_byte, 8'hAA);
    chk({base_high, base_low}, 16'h0000);
    repeat (4) @(posedge clk);
    #1;
    foreach (ams[i]) begin
      try(ams[i], {rotary_high, rotary_low}, 1'b1);
      try(ams[i], {rotary_high, rotary_low}, 1'b0);
    end
    repeat (8) try(6'($random(seed)), {rotary_high, rotary_low}, 1'b1);
    $display("test switch base done");
    base_high_in = 8'($random(seed));
    base_low_in = ~rotary_low;
    base_src_in = 1'b1;
    base_wr = 1'b1;
    base_src_wr = 1'b1;
    @(posedge clk);
    #1 {base_wr, base_src_wr} = 2'h0;
    chk(base_src, 1'b1);
    chk({base_high, base_low}, {base_high_in, base_low_in});
    try(6'h0D, {base_high_in, base_low_in}, 1'b1);
    try(6'h3B, {base_high_in, base_low_in}, 1'b1);
    try(6'h09, {rotary_high, rotary_low}, 1'b0);
    acc(6'h09, {base_high_in, base_low_in, 15'h0002}, 1'b1);
    chk(reg_width_ok, 1'b0);
    fin;
    $display("test register base done");
    mcst_byte_in = 8'($random(seed));
    mcst_wr = 1'b1;
    @(posedge clk);
    #1 mcst_wr = 1'b0;
    chk(mcst_byte, mcst_byte_in);
    acc(6'h0D, {mcst_byte_in, 8'h00, 15'h0123}, 1'b0);
    chk(mcst_select, 1'b1);
    fin;
    acc(6'h0C, {mcst_byte_in, 8'h00, 15'h0123}, 1'b0);
    chk(mcst_select, 1'b0);
    fin;
    $display("test multicast done");
    for (int l = 0; l < 8; l++) begin
      irq_level = 3'(l);
      irq_event = 1'b1;
      @(posedge clk);
      #1 irq_event = 1'b0;
      chk(irq_n, l == 0 ? 7'h7F : 7'h7F & ~(7'h01 << (l - 1)));
      try(6'h39, {base_high_in, base_low_in}, 1'b1);
      chk(irq_n, 7'h7F);
    end
    // Request raised while an access stands: request first, release next edge
    acc(6'h39, {base_high_in, base_low_in, 15'h0000}, 1'b0);
    irq_level = 3'h5;
    irq_event = 1'b1;
    @(posedge clk);
    #1 irq_event = 1'b0;
    chk(irq_n, 7'h6F);
    @(posedge clk);
    #1;
    chk(irq_n, 7'h7F);
    fin;
    $display("test interrupter done");
    report_and_stop;
  end
  // Watchdog, far beyond the expected run
  initial begin
    #100000;
    errors++;
    report_and_stop;
  end
  task report_and_stop;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
endmodule
